// *** inc/blank_ctl_pkg.sv ***
// package: shared types and timing constants for the blanking and burst control unit
package blank_ctl_pkg;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_MHZ = 250;          // timing clock rate
  localparam int BLANK_TIME_MS = 20;     // basic blanking interval
  localparam int SPIKE_TIME_US = 30;     // spike filter after the restart-enable gate opens
  // exact multiples of the clock period, so no rounding is needed
  localparam int BLANK_CYC = BLANK_TIME_MS * 1000 * CLK_MHZ;
  localparam int SPIKE_CYC = SPIKE_TIME_US * CLK_MHZ;

  // ***********************************************
  // reset values of the control outputs
  // ***********************************************
  localparam logic RST_BURST_FLAG = 1'b0;
  localparam logic RST_BIAS_EN = 1'b1;
  localparam logic RST_REDUCED_LIMIT = 1'b0;
  localparam logic RST_CLAMP_RELEASE = 1'b0;
  localparam logic RST_STARTUP_CELL = 1'b0;
  localparam logic RST_SWITCH_EN = 1'b1;
  localparam logic RST_SOFT_START_GO = 1'b0;
  localparam logic RST_RESTART_ACTIVE = 1'b0;

  // ***********************************************
  // comparator and fault decisions, as they arrive from the analog side
  // ***********************************************
  typedef struct packed {
    logic low_feedback_comparator;   // feedback below 1.22 V
    logic high_feedback_comparator;  // feedback above 4.5 V
    logic burst_upper_comparator;    // feedback above 3.6 V
    logic burst_lower_comparator;    // feedback down at 3.1 V
    logic blanking_pin_comparator;   // blanking pin has reached 4.0 V
    logic vcc_overvoltage;           // supply above 25.5 V
    logic over_temperature;
    logic vcc_undervoltage;          // supply at turn-off threshold
    logic opto_short;
    logic ext_restart;               // external restart request
    logic vcc_turn_on;               // supply at turn-on threshold
    logic soft_start_done;           // startup phase finished
  } cmp_t;

  // ***********************************************
  // operating modes
  // ***********************************************
  typedef enum logic [1:0] {
    st_normal,
    st_burst,
    st_restart,
    st_startup
  } mode_t;

endpackage

// *** logic/sync_two_ff.sv ***
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// *** logic/blank_ctl.sv ***
// control unit: basic and extendable blanking, low-load burst mode, auto-restart sequencing
`timescale 1ns/100ps
module blank_ctl #(
  parameter int BLANK_CYCLES = blank_ctl_pkg::BLANK_CYC,
  parameter int SPIKE_CYCLES = blank_ctl_pkg::SPIKE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input blank_ctl_pkg::cmp_t cmp_raw,
  output logic burst_flag,
  output logic bias_en,
  output logic reduced_limit_gate,
  output logic clamp_release,
  output logic startup_cell_en,
  output logic switch_en,
  output logic soft_start_go,
  output logic restart_active
);
  import blank_ctl_pkg::*;

  localparam int BW = $clog2(BLANK_CYCLES + 1);
  localparam int SW = $clog2(SPIKE_CYCLES + 1);
  localparam logic [BW-1:0] BLANK_LAST = BW'(BLANK_CYCLES - 1);
  localparam logic [SW-1:0] SPIKE_LAST = SW'(SPIKE_CYCLES - 1);

  // ***********************************************
  // input synchronisation
  // ***********************************************
  cmp_t cmp;

  // every comparator decision is asynchronous to the timing clock
  sync_two_ff #(
    .W($bits(cmp_t))
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(cmp_raw),
    .q(cmp)
  );

  // ***********************************************
  // state and counters
  // ***********************************************
  mode_t state_q;
  mode_t state_d;
  logic [BW-1:0] blank_cnt_q;
  logic [SW-1:0] spike_cnt_q;
  logic high_cause_q;
  logic burst_flag_q;
  logic bias_en_q;
  logic reduced_limit_q;
  logic clamp_release_q;
  logic startup_cell_q;
  logic switch_en_q;
  logic soft_start_go_q;
  logic restart_active_q;

  logic in_normal;
  logic cause_low;
  logic cause_high;
  logic blank_done;
  logic gate_open;
  logic spike_done;
  logic fast_fault;
  logic burst_enter;
  logic restart_fire;

  // ***********************************************
  // decisions
  // ***********************************************
  assign in_normal = (state_q == st_normal);
  // low feedback arms burst, high feedback arms overload / open loop
  assign cause_low = in_normal & cmp.low_feedback_comparator;
  assign cause_high = in_normal & cmp.high_feedback_comparator;
  assign blank_done = (blank_cnt_q == BLANK_LAST);
  // the gate stays blocked until the external capacitor has charged up
  assign gate_open = clamp_release_q & cmp.blanking_pin_comparator;
  assign spike_done = (spike_cnt_q == SPIKE_LAST);
  // burst only needs the basic interval, restart also waits on the pin
  assign burst_enter = cause_low & blank_done;
  assign restart_fire = gate_open & spike_done;
  // supply overvoltage is ignored while bursting
  assign fast_fault = (cmp.vcc_overvoltage & (state_q != st_burst))
                    | cmp.over_temperature
                    | cmp.vcc_undervoltage
                    | cmp.opto_short
                    | cmp.ext_restart;

  // ***********************************************
  // mode sequencing
  // ***********************************************
  // next mode; fast faults beat every blanked event
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_normal: begin
        if (fast_fault || restart_fire) begin
          state_d = st_restart;
        end else if (burst_enter) begin
          state_d = st_burst;
        end
      end
      st_burst: begin
        if (fast_fault) begin
          state_d = st_restart;
        end else if (cmp.high_feedback_comparator) begin
          state_d = st_normal;
        end
      end
      st_restart: begin
        // leave only once the cell has recharged the supply
        if (startup_cell_q && cmp.vcc_turn_on) begin
          state_d = st_startup;
        end
      end
      st_startup: begin
        if (fast_fault) begin
          state_d = st_restart;
        end else if (cmp.soft_start_done) begin
          state_d = st_normal;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= st_normal;
    end else begin
      state_q <= state_d;
    end
  end

  // ***********************************************
  // basic blanking counter
  // ***********************************************
  // remembers which cause is being timed so a swap restarts the window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_cause_q <= 1'b0;
    end else begin
      high_cause_q <= cause_high;
    end
  end

  // held at zero unless one cause is present; saturates at the end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blank_cnt_q <= '0;
    end else if (!(cause_low ^ cause_high) || (cause_high != high_cause_q)) begin
      blank_cnt_q <= '0;
    end else if (!blank_done) begin
      blank_cnt_q <= blank_cnt_q + 1'b1;
    end
  end

  // ***********************************************
  // clamp release and spike filter
  // ***********************************************
  // dropping the high feedback closes the window and re-clamps the pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clamp_release_q <= RST_CLAMP_RELEASE;
    end else if (!cause_high || state_d != st_normal) begin
      clamp_release_q <= 1'b0;
    end else if (blank_done) begin
      clamp_release_q <= 1'b1;
    end
  end

  // a glitch on the pin comparator restarts the filter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spike_cnt_q <= '0;
    end else if (!gate_open) begin
      spike_cnt_q <= '0;
    end else if (!spike_done) begin
      spike_cnt_q <= spike_cnt_q + 1'b1;
    end
  end

  // ***********************************************
  // burst controls
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burst_flag_q <= RST_BURST_FLAG;
    end else begin
      burst_flag_q <= (state_d == st_burst);
    end
  end

  // reduced limit tracks the burst mode exactly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reduced_limit_q <= RST_REDUCED_LIMIT;
    end else begin
      reduced_limit_q <= (state_d == st_burst);
    end
  end

  // bias follows the burst hysteresis; upper crossing wins if both report
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bias_en_q <= RST_BIAS_EN;
    end else if (state_d == st_restart) begin
      bias_en_q <= 1'b0;
    end else if (state_d != st_burst) begin
      bias_en_q <= 1'b1;
    end else if (state_q != st_burst) begin
      bias_en_q <= 1'b0;
    end else if (cmp.burst_upper_comparator) begin
      bias_en_q <= 1'b1;
    end else if (cmp.burst_lower_comparator) begin
      bias_en_q <= 1'b0;
    end
  end

  // switching goes with the bias inside burst and stops in restart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      switch_en_q <= RST_SWITCH_EN;
    end else if (state_d == st_restart) begin
      switch_en_q <= 1'b0;
    end else if (state_d != st_burst) begin
      switch_en_q <= 1'b1;
    end else if (state_q != st_burst) begin
      switch_en_q <= 1'b0;
    end else if (cmp.burst_upper_comparator) begin
      switch_en_q <= 1'b1;
    end else if (cmp.burst_lower_comparator) begin
      switch_en_q <= 1'b0;
    end
  end

  // ***********************************************
  // restart supply cycling
  // ***********************************************
  // cell only runs while restarting; burst relies on the supply staying up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      startup_cell_q <= RST_STARTUP_CELL;
    end else if (state_d != st_restart) begin
      startup_cell_q <= 1'b0;
    end else if (cmp.vcc_undervoltage) begin
      startup_cell_q <= 1'b1;
    end
  end

  // one pulse at the start of every startup phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_start_go_q <= RST_SOFT_START_GO;
      restart_active_q <= RST_RESTART_ACTIVE;
    end else begin
      soft_start_go_q <= (state_d == st_startup) && (state_q != st_startup);
      restart_active_q <= (state_d == st_restart);
    end
  end

  assign burst_flag = burst_flag_q;
  assign bias_en = bias_en_q;
  assign reduced_limit_gate = reduced_limit_q;
  assign clamp_release = clamp_release_q;
  assign startup_cell_en = startup_cell_q;
  assign switch_en = switch_en_q;
  assign soft_start_go = soft_start_go_q;
  assign restart_active = restart_active_q;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_gate_open;
    clamp_release_q && cmp.blanking_pin_comparator;
  endsequence

  sequence s_filter_end;
    s_gate_open and (spike_cnt_q == SPIKE_LAST && in_normal && !fast_fault);
  endsequence

  cell_in_burst_a: assert property (burst_flag_q |-> !startup_cell_q)
    else $error("startup cell on during burst");

  limit_tracks_a: assert property (reduced_limit_q == burst_flag_q)
    else $error("reduced limit differs from burst flag");

  burst_cause_a: assert property ($rose(burst_flag_q) |->
      $past(blank_cnt_q) == BLANK_LAST && $past(cmp.low_feedback_comparator))
    else $error("burst entered without full low-feedback window");

  burst_bias_a: assert property (in_normal && burst_enter && !fast_fault |=>
      burst_flag_q && !bias_en_q && !switch_en_q)
    else $error("burst entry did not set flag and drop bias");

  count_idle_a: assert property (in_normal && !cmp.low_feedback_comparator
      && !cmp.high_feedback_comparator |=> blank_cnt_q == '0)
    else $error("blanking counter not held at zero");

  clamp_cause_a: assert property ($rose(clamp_release_q) |->
      $past(blank_cnt_q) == BLANK_LAST && $past(cmp.high_feedback_comparator))
    else $error("clamp released before blanking ended");

  spike_wait_a: assert property (s_filter_end |=> state_q == st_restart)
    else $error("restart not entered after spike filter");

  gate_block_a: assert property (in_normal && !fast_fault && !(clamp_release_q && cmp.blanking_pin_comparator)
      |=> state_q != st_restart)
    else $error("restart entered with gate closed");

  burst_up_a: assert property (state_q == st_burst && state_d == st_burst
      && cmp.burst_upper_comparator |=> bias_en_q && switch_en_q)
    else $error("bias not resumed at upper threshold");

  burst_down_a: assert property (state_q == st_burst && state_d == st_burst
      && cmp.burst_lower_comparator && !cmp.burst_upper_comparator |=> !bias_en_q)
    else $error("bias not dropped at lower threshold");

  burst_exit_a: assert property (state_q == st_burst && !fast_fault
      && cmp.high_feedback_comparator |=> !burst_flag_q && !reduced_limit_q)
    else $error("burst not left on high feedback");

  fast_fault_a: assert property (in_normal && fast_fault |=>
      restart_active_q && !switch_en_q)
    else $error("unblanked fault did not restart at once");

  cell_cycle_a: assert property (state_q == st_restart && state_d == st_restart
      && cmp.vcc_undervoltage |=> startup_cell_q)
    else $error("startup cell not enabled at turn-off");

  soft_rerun_a: assert property (state_q == st_restart && startup_cell_q
      && cmp.vcc_turn_on |=> soft_start_go_q ##1 !soft_start_go_q)
    else $error("soft start not rerun on restart attempt");

endmodule

// *** bench/analog_side.sv ***
// partner model: comparators, blanking-pin charging, supply and soft start of the converter side
`timescale 1ns/100ps
module analog_side #(
  parameter int VCC_TOP = 16,
  parameter int SS_CYC = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [12:0] fb_mv,
  input wire logic [7:0] ext_cyc,
  input wire logic [4:0] fault,
  input wire logic clamp_release,
  input wire logic startup_cell_en,
  input wire logic soft_start_go,
  input wire logic restart_active,
  output blank_ctl_pkg::cmp_t cmp_raw
);
  import blank_ctl_pkg::*;
  logic [7:0] pin_q;
  logic [4:0] vcc_q;
  logic [5:0] ss_q;
  logic done_q;
  // pin is clamped low until released, then charges for ext_cyc periods
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pin_q <= 8'h00;
    else if (!clamp_release) pin_q <= 8'h00;
    else if (pin_q != 8'hff) pin_q <= pin_q + 8'h01;
  end
  // supply sags while idle in restart and climbs while the startup cell feeds it
  // an undervoltage fault collapses the supply, so the flag cannot outlive a recharge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) vcc_q <= 5'(VCC_TOP);
    else if (fault[2]) vcc_q <= 5'h00;
    else if (startup_cell_en && vcc_q != 5'(VCC_TOP)) vcc_q <= vcc_q + 5'h01;
    else if (restart_active && !startup_cell_en && vcc_q != 5'h00) vcc_q <= vcc_q - 5'h01;
  end
  // soft start length counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ss_q <= 6'h00;
    else if (soft_start_go) ss_q <= 6'(SS_CYC);
    else if (ss_q != 6'h00) ss_q <= ss_q - 6'h01;
  end
  // done cleared in restart so a stale level never ends the next startup early
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) done_q <= 1'b0;
    else if (restart_active || soft_start_go) done_q <= 1'b0;
    else if (ss_q == 6'h01) done_q <= 1'b1;
  end
  // comparator decisions from the feedback level in millivolts
  always_comb begin
    cmp_raw.low_feedback_comparator = fb_mv < 13'h4c4;
    cmp_raw.high_feedback_comparator = fb_mv > 13'h1194;
    cmp_raw.burst_upper_comparator = fb_mv > 13'he10;
    cmp_raw.burst_lower_comparator = fb_mv <= 13'hc1c;
    cmp_raw.blanking_pin_comparator = clamp_release && pin_q >= ext_cyc;
    cmp_raw.vcc_overvoltage = fault[0];
    cmp_raw.over_temperature = fault[1];
    cmp_raw.vcc_undervoltage = (vcc_q == 5'h00);
    cmp_raw.opto_short = fault[3];
    cmp_raw.ext_restart = fault[4];
    cmp_raw.vcc_turn_on = vcc_q == 5'(VCC_TOP);
    cmp_raw.soft_start_done = done_q;
  end
endmodule

// *** bench/tb_blank_ctl.sv ***
// self-checking bench for the blanking, burst and auto-restart control unit
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_blank_ctl;
  import blank_ctl_pkg::*;
  localparam int BLK = 40;
  localparam int SPK = 8;
  localparam int SSC = 20;
  logic clk;
  logic rstn;
  logic [12:0] fb_mv;
  logic [7:0] ext_cyc;
  logic [4:0] fault;
  logic [31:0] seed;
  logic [7:0] outs;
  cmp_t cmp_raw;
  logic burst_flag, bias_en, reduced_limit_gate, clamp_release;
  logic startup_cell_en, switch_en, soft_start_go, restart_active;
  int errors;
  int cmp_count;
  int k;

  blank_ctl #(.BLANK_CYCLES(BLK), .SPIKE_CYCLES(SPK)) DUT (
    .clk(clk), .rstn(rstn), .cmp_raw(cmp_raw), .burst_flag(burst_flag), .bias_en(bias_en),
    .reduced_limit_gate(reduced_limit_gate), .clamp_release(clamp_release),
    .startup_cell_en(startup_cell_en), .switch_en(switch_en), .soft_start_go(soft_start_go),
    .restart_active(restart_active));
  analog_side #(.VCC_TOP(16), .SS_CYC(SSC)) model (
    .clk(clk), .rstn(rstn), .fb_mv(fb_mv), .ext_cyc(ext_cyc), .fault(fault), .clamp_release(clamp_release),
    .startup_cell_en(startup_cell_en), .soft_start_go(soft_start_go), .restart_active(restart_active),
    .cmp_raw(cmp_raw));
  // bit 0 burst, 1 reduced, 2 bias, 3 clamp, 4 cell, 5 switch, 6 soft start, 7 restart
  assign outs = {restart_active, soft_start_go, switch_en, startup_cell_en,
                 clamp_release, bias_en, reduced_limit_gate, burst_flag};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic close_out();
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic drive_fb(input logic [12:0] v);
    @(posedge clk);
    fb_mv <= v;
    #1;
  endtask

  // bounded wait on one output; running out ends the run
  task automatic wait_out(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[i] !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(outs[i], v)
    if (outs[i] !== v) close_out();
  endtask

  // ride out one restart cycle with the fault gone
  task automatic recover();
    wait_out(4, 1'b1, 60);
    wait_out(6, 1'b1, 60);
    `CHK(outs, 8'h64)
    step(1);
    `CHK(soft_start_go, 1'b0)
    step(SSC + 8);
    `CHK(outs, 8'h24)
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    close_out();
  end

  // ***********************************************
  // scenarios
  // ***********************************************
  initial begin
    rstn = 1'b0;
    fb_mv = 13'h7d0;
    ext_cyc = 8'h00;
    fault = 5'h00;
    seed = 32'h4c30;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    step(1);
    `CHK(outs, 8'h24)
    // mid-range feedback never starts burst nor the overload clamp
    repeat (12) begin
      drive_fb(13'h514 + 13'(rnd() % 3000));
      step(int'(rnd() % 20));
      `CHK(outs, 8'h24)
    end
    // two low stretches just short of the interval; a brief recovery must zero the count
    repeat (2) begin
      drive_fb(13'h3e8);
      step(BLK - 6);
      drive_fb(13'h7d0);
      step(1);
    end
    step(4);
    `CHK(burst_flag, 1'b0)
    // fast faults act one clock after the synchroniser delay, far inside the blanking interval
    for (k = 0; k < 5; k++) begin
      @(posedge clk);
      fault[k] <= 1'b1;
      #1;
      wait_out(7, 1'b1, 5);
      `CHK(switch_en, 1'b0)
      if (k == 1) begin
        wait_out(6, 1'b1, 80);
        wait_out(7, 1'b1, 6);
      end
      @(posedge clk);
      fault[k] <= 1'b0;
      #1;
      recover();
    end
    // low feedback held for the whole interval enters burst
    drive_fb(13'h3e8);
    step(BLK - 1);
    `CHK(burst_flag, 1'b0)
    wait_out(0, 1'b1, 8);
    step(1);
    `CHK(outs, 8'h03)
    // bias and switching follow the burst comparators, reduced limit held throughout
    repeat (3) begin
      drive_fb(13'he74 + 13'(rnd() % 600));
      wait_out(2, 1'b1, 5);
      `CHK(outs, 8'h27)
      drive_fb(13'h5dc + 13'(rnd() % 1500));
      wait_out(2, 1'b0, 5);
      `CHK(outs, 8'h03)
    end
    @(posedge clk);
    fault[0] <= 1'b1;
    step(6);
    `CHK(outs, 8'h03)
    @(posedge clk);
    fault[0] <= 1'b0;
    ext_cyc <= 8'hc8;
    // load jump leaves burst, then the same high level starts overload blanking
    drive_fb(13'h11f8);
    wait_out(0, 1'b1 ^ 1'b1, 5);
    `CHK(outs, 8'h24)
    step(BLK - 6);
    `CHK(clamp_release, 1'b0)
    wait_out(3, 1'b1, 12);
    step(20);
    `CHK(restart_active, 1'b0)
    drive_fb(13'h7d0);
    wait_out(3, 1'b0, 5);
    // overload again with a random extension; spike filter must hold off restart
    @(posedge clk);
    ext_cyc <= 8'(rnd() % 40);
    step(4);
    drive_fb(13'h11f8);
    wait_out(3, 1'b1, BLK + 6);
    step(int'(ext_cyc) + SPK - 1);
    `CHK(restart_active, 1'b0)
    wait_out(7, 1'b1, 10);
    `CHK(switch_en, 1'b0)
    drive_fb(13'h7d0);
    recover();
    close_out();
  end
endmodule
